// *** src/uef_top.sv ***
/*
 USB endpoint FIFO pointers: three transmit and three receive byte FIFOs,
 their pointers, levels, warnings, sticky events and masked interrupt,
 all behind an AXI4-Lite register slave.
 Assumes one clock, synchronous active-low reset, and an endpoint
 controller that pulses one take or store per FIFO per cycle.
*/
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uef_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [uef_pkg::ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [uef_pkg::ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Endpoint controller, transmit side
  input wire logic [uef_pkg::NUM_EP-1:0] tx_take,
  output logic [uef_pkg::NUM_EP-1:0][7:0] tx_byte,
  output logic [uef_pkg::NUM_EP-1:0] tx_byte_valid,
  // Endpoint controller, receive side
  input wire logic [uef_pkg::NUM_EP-1:0] rx_store,
  input wire logic [uef_pkg::NUM_EP-1:0][7:0] rx_byte,
  // Interrupt
  output logic usb_irq
);

  typedef struct packed {
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::DEPTH-1:0][7:0] tx_mem;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::DEPTH-1:0][7:0] rx_mem;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::PTR_W-1:0] tx_read_ptr;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::PTR_W-1:0] tx_write_ptr;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::PTR_W-1:0] rx_read_ptr;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::PTR_W-1:0] rx_write_ptr;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] tx_fill_level;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] rx_held;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] tx_warn_threshold;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] rx_warn_threshold;
    logic [uef_pkg::NUM_EP-1:0] tx_last;
    logic [uef_pkg::NUM_EP-1:0][7:0] rx_last_byte;
    logic [uef_pkg::NUM_EP-1:0][7:0] tx_out;
    logic [uef_pkg::NUM_EP-1:0] tx_out_valid;
    logic [uef_pkg::NUM_EV-1:0] main_event_reg;
    logic [7:0] main_mask_reg;
    logic [uef_pkg::NUM_EV-1:0] fifo_warning_reg;
    logic aw_full;
    logic [uef_pkg::ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } uef_state_t;

  uef_state_t s_q;
  uef_state_t s_d;

  // Pointer step; 6-bit width makes the wrap at 64 natural
  function automatic logic [uef_pkg::PTR_W-1:0] ptr_inc(input logic [uef_pkg::PTR_W-1:0] p);
    ptr_inc = p + uef_pkg::PTR_W'(1);
  endfunction

  function automatic logic [uef_pkg::LVL_W-1:0] lvl_step(
      input logic [uef_pkg::LVL_W-1:0] l, input logic up, input logic dn);
    lvl_step = l + uef_pkg::LVL_W'(up) - uef_pkg::LVL_W'(dn);
  endfunction

  // Empty bytes in a FIFO holding l bytes; shared by status and warning
  function automatic logic [uef_pkg::LVL_W-1:0] room(input logic [uef_pkg::LVL_W-1:0] l);
    room = uef_pkg::FIFO_SIZE - l;
  endfunction

  function automatic logic [uef_pkg::ADDR_W-1:0] ep_addr(
      input logic [uef_pkg::ADDR_W-1:0] base, input int i,
      input logic [uef_pkg::ADDR_W-1:0] ofs);
    ep_addr = base + uef_pkg::ADDR_W'(i) * uef_pkg::EP_STRIDE + ofs;
  endfunction

  always_comb begin
    logic do_wr;
    logic do_rd;
    logic wr_hit;
    logic rd_hit;
    logic wr_en;
    logic put;
    logic get;
    logic [uef_pkg::ADDR_W-1:0] ra;
    logic [uef_pkg::ADDR_W-1:0] wa;
    logic [uef_pkg::NUM_EV-1:0] ev_set;
    logic [uef_pkg::NUM_EV-1:0] ev_clr;
    logic [uef_pkg::NUM_EV-1:0] flush;
    logic [7:0] rbyte;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] tx_free_count;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] rx_space_level;
    logic [uef_pkg::NUM_EP-1:0][uef_pkg::LVL_W-1:0] rx_avail_count;
    logic [uef_pkg::NUM_EV-1:0] fifo_warn_flag;
    do_wr = 1'b0;
    do_rd = 1'b0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    wr_en = 1'b0;
    put = 1'b0;
    get = 1'b0;
    ra = araddr;
    wa = s_q.aw_addr;
    ev_set = '0;
    ev_clr = '0;
    flush = '0;
    rbyte = 8'h00;
    fifo_warn_flag = '0;
    s_d = s_q;

    // Derived counts come from registered levels only, so status reads and
    // warnings never see a half-updated level
    for (int i = 0; i < uef_pkg::NUM_EP; i++) begin
      tx_free_count[i] = room(s_q.tx_fill_level[i]);
      rx_space_level[i] = room(s_q.rx_held[i]);
      rx_avail_count[i] = s_q.rx_held[i];
    end

    // Bus handshakes; one write and one read in flight at a time
    if (awvalid && awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    if (s_q.b_valid && bready) begin
      s_d.b_valid = 1'b0;
    end
    if (s_q.r_valid && rready) begin
      s_d.r_valid = 1'b0;
    end
    do_wr = s_q.aw_full && s_q.w_full && !s_q.b_valid;
    do_rd = arvalid && !s_q.r_valid;
    // All fields sit in byte lane 0; a write without that lane stores nothing
    wr_en = do_wr && s_q.w_lane0;

    // Control register writes
    if (do_wr) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.b_valid = 1'b1;
      if (wa == uef_pkg::MAIN_EVENT_ADDR) begin
        wr_hit = 1'b1;
        if (wr_en) ev_clr = s_q.w_data[uef_pkg::NUM_EV-1:0];
      end
      if (wa == uef_pkg::MAIN_MASK_ADDR) begin
        wr_hit = 1'b1;
        if (wr_en) s_d.main_mask_reg = s_q.w_data;
      end
      if (wa == uef_pkg::FIFO_WARNING_ADDR) begin
        wr_hit = 1'b1;
      end
      if (wa == uef_pkg::FLUSH_ADDR) begin
        wr_hit = 1'b1;
        if (wr_en) flush = s_q.w_data[uef_pkg::NUM_EV-1:0];
      end
      for (int i = 0; i < uef_pkg::NUM_EP; i++) begin
        if (wa == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::CTRL_OFS)) begin
          wr_hit = 1'b1;
          if (wr_en) s_d.tx_warn_threshold[i] = s_q.w_data[uef_pkg::LVL_W-1:0];
        end
        if (wa == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::CMD_OFS)) begin
          wr_hit = 1'b1;
          // Final-chunk bit stays until firmware clears it; it only silences underrun
          if (wr_en) s_d.tx_last[i] = s_q.w_data[uef_pkg::CMD_LAST_BIT];
        end
        if (wa == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::CTRL_OFS)) begin
          wr_hit = 1'b1;
          if (wr_en) s_d.rx_warn_threshold[i] = s_q.w_data[uef_pkg::LVL_W-1:0];
        end
        // Data and status words answer OKAY even where a write has no effect
        if (wa == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::DATA_OFS) ||
            wa == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::STAT_OFS) ||
            wa == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::DATA_OFS) ||
            wa == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::STAT_OFS)) begin
          wr_hit = 1'b1;
        end
      end
      s_d.b_resp = wr_hit ? uef_pkg::RESP_OKAY : uef_pkg::RESP_SLVERR;
    end

    // Transmit FIFOs: firmware fills, endpoint controller drains
    for (int i = 0; i < uef_pkg::NUM_EP; i++) begin
      put = wr_en && wa == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::DATA_OFS) &&
            s_q.tx_fill_level[i] != uef_pkg::FIFO_SIZE;
      get = tx_take[i] && s_q.tx_fill_level[i] != '0;
      s_d.tx_out_valid[i] = 1'b0;
      if (put) begin
        s_d.tx_mem[i][s_q.tx_write_ptr[i]] = s_q.w_data;
        s_d.tx_write_ptr[i] = ptr_inc(s_q.tx_write_ptr[i]);
      end
      if (get) begin
        // Read pointer only moves while bytes are held
        // Byte stays registered until the next take that finds a byte, so it may be sampled late
        s_d.tx_out[i] = s_q.tx_mem[i][s_q.tx_read_ptr[i]];
        s_d.tx_out_valid[i] = 1'b1;
        s_d.tx_read_ptr[i] = ptr_inc(s_q.tx_read_ptr[i]);
      end
      if (tx_take[i] && s_q.tx_fill_level[i] == '0 && !s_q.tx_last[i]) begin
        ev_set[i] = 1'b1;
      end
      s_d.tx_fill_level[i] = lvl_step(s_q.tx_fill_level[i], put, get);
      if (flush[i]) begin
        s_d.tx_read_ptr[i] = '0;
        s_d.tx_write_ptr[i] = '0;
        s_d.tx_fill_level[i] = '0;
      end
      // Warning follows the level one cycle later; a flush forces it low once
      fifo_warn_flag[i] = !flush[i] &&
          s_q.tx_fill_level[i] <= s_q.tx_warn_threshold[i];
    end

    // Receive FIFOs: endpoint controller fills, firmware drains
    for (int i = 0; i < uef_pkg::NUM_EP; i++) begin
      put = rx_store[i] && s_q.rx_held[i] != uef_pkg::FIFO_SIZE;
      get = do_rd && ra == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::DATA_OFS) &&
            s_q.rx_held[i] != '0;
      if (put) begin
        s_d.rx_mem[i][s_q.rx_write_ptr[i]] = rx_byte[i];
        s_d.rx_write_ptr[i] = ptr_inc(s_q.rx_write_ptr[i]);
      end
      // A store into a full FIFO is lost; only the event remembers it
      if (rx_store[i] && s_q.rx_held[i] == uef_pkg::FIFO_SIZE) begin
        ev_set[uef_pkg::EV_RX_BASE + i] = 1'b1;
      end
      if (get) begin
        s_d.rx_last_byte[i] = s_q.rx_mem[i][s_q.rx_read_ptr[i]];
        s_d.rx_read_ptr[i] = ptr_inc(s_q.rx_read_ptr[i]);
      end
      s_d.rx_held[i] = lvl_step(s_q.rx_held[i], put, get);
      if (flush[uef_pkg::EV_RX_BASE + i]) begin
        s_d.rx_read_ptr[i] = '0;
        s_d.rx_write_ptr[i] = '0;
        s_d.rx_held[i] = '0;
      end
      fifo_warn_flag[uef_pkg::EV_RX_BASE + i] = !flush[uef_pkg::EV_RX_BASE + i] &&
          rx_space_level[i] <= s_q.rx_warn_threshold[i];
    end

    // Register reads; a receive data read pops as a side effect
    if (do_rd) begin
      s_d.r_valid = 1'b1;
      s_d.r_data = '0;
      if (ra == uef_pkg::MAIN_EVENT_ADDR) begin
        rd_hit = 1'b1;
        s_d.r_data[uef_pkg::NUM_EV-1:0] = s_q.main_event_reg;
      end
      if (ra == uef_pkg::MAIN_MASK_ADDR) begin
        rd_hit = 1'b1;
        s_d.r_data[7:0] = s_q.main_mask_reg;
      end
      if (ra == uef_pkg::FIFO_WARNING_ADDR) begin
        rd_hit = 1'b1;
        s_d.r_data[uef_pkg::NUM_EV-1:0] = s_q.fifo_warning_reg;
      end
      if (ra == uef_pkg::FLUSH_ADDR) begin
        rd_hit = 1'b1;
      end
      for (int i = 0; i < uef_pkg::NUM_EP; i++) begin
        if (ra == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::CTRL_OFS)) begin
          rd_hit = 1'b1;
          s_d.r_data[uef_pkg::LVL_W-1:0] = s_q.tx_warn_threshold[i];
        end
        if (ra == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::CMD_OFS)) begin
          rd_hit = 1'b1;
          s_d.r_data[uef_pkg::CMD_LAST_BIT] = s_q.tx_last[i];
        end
        if (ra == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::DATA_OFS)) begin
          rd_hit = 1'b1;
        end
        if (ra == ep_addr(uef_pkg::TX_BASE, i, uef_pkg::STAT_OFS)) begin
          rd_hit = 1'b1;
          // Free count, size minus level
          s_d.r_data[uef_pkg::LVL_W-1:0] = tx_free_count[i];
        end
        if (ra == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::CTRL_OFS)) begin
          rd_hit = 1'b1;
          s_d.r_data[uef_pkg::LVL_W-1:0] = s_q.rx_warn_threshold[i];
        end
        if (ra == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::DATA_OFS)) begin
          rd_hit = 1'b1;
          // Empty FIFO hands back the previous byte again
          rbyte = (s_q.rx_held[i] != '0) ? s_q.rx_mem[i][s_q.rx_read_ptr[i]]
                                          : s_q.rx_last_byte[i];
          s_d.r_data[7:0] = rbyte;
        end
        if (ra == ep_addr(uef_pkg::RX_BASE, i, uef_pkg::STAT_OFS)) begin
          rd_hit = 1'b1;
          s_d.r_data[uef_pkg::LVL_W-1:0] = rx_avail_count[i];
        end
      end
      s_d.r_resp = rd_hit ? uef_pkg::RESP_OKAY : uef_pkg::RESP_SLVERR;
    end

    // Warning register only follows the flags; software cannot write it
    s_d.fifo_warning_reg = fifo_warn_flag;

    // Sticky events: a set in the clearing cycle survives
    s_d.main_event_reg = (s_q.main_event_reg & ~ev_clr) | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Ready terms stall while the slot is full or the answer waits
  assign awready = !s_q.aw_full && !s_q.b_valid;
  assign wready = !s_q.w_full && !s_q.b_valid;
  assign arready = !s_q.r_valid;
  assign bvalid = s_q.b_valid;
  assign bresp = s_q.b_resp;
  assign rvalid = s_q.r_valid;
  assign rdata = s_q.r_data;
  assign rresp = s_q.r_resp;
  assign tx_byte = s_q.tx_out;
  assign tx_byte_valid = s_q.tx_out_valid;
  assign usb_irq = s_q.main_mask_reg[uef_pkg::MASK_GLOBAL_BIT] &&
      |(s_q.main_event_reg & s_q.main_mask_reg[uef_pkg::NUM_EV-1:0]);

endmodule
`default_nettype wire

// *** shared/uef_pkg.sv ***
/*
 Constants for the USB endpoint FIFO pointer block: register map, field
 positions, sizes and bus response codes. Assumes byte addresses on an
 AXI4-Lite slave with 32-bit data and an 8-bit address window.
*/
package uef_pkg;
  localparam int NUM_EP = 3;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int LVL_W = 7;
  localparam int ADDR_W = 8;
  localparam logic [LVL_W-1:0] FIFO_SIZE = 7'h40;
  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] MAIN_EVENT_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] MAIN_MASK_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] FIFO_WARNING_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] FLUSH_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] TX_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] RX_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] EP_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] DATA_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h0C;
  // Fields
  localparam int MASK_GLOBAL_BIT = 7;
  localparam int CMD_LAST_BIT = 0;
  localparam int EV_RX_BASE = 3;
  localparam int NUM_EV = 6;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** dv/uef_props.sv ***
/*
 Port checker for uef_top: bus answers and endpoint byte timing.
 Assumes binding from the bench top and the hand-over latencies.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Endpoint link
  input wire logic [2:0] tx_take,
  input wire logic [2:0][7:0] tx_byte,
  input wire logic [2:0] tx_byte_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_done;
    ##2 bvalid;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> s_wr_done;
  endproperty
  property p_rd_answer;
    arvalid && arready |=> rvalid;
  endproperty
  property p_w_refused;
    bvalid |-> !awready && !wready;
  endproperty
  property p_ar_refused;
    rvalid |-> !arready;
  endproperty
  property p_b_once;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_r_once;
    rvalid && rready |=> !rvalid;
  endproperty
  // Byte shown only for a take one cycle earlier
  property p_tx_cause;
    tx_byte_valid != 3'h0 |-> (tx_byte_valid & ~$past(tx_take)) == 3'h0;
  endproperty
  property p_tx_hold;
    tx_take == 3'h0 |=> $stable(tx_byte);
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_w_refused: assert property (p_w_refused) else $error("write taken early");
  a_ar_refused: assert property (p_ar_refused) else $error("read taken early");
  a_b_once: assert property (p_b_once) else $error("response repeated");
  a_r_once: assert property (p_r_once) else $error("read data repeated");
  a_tx_cause: assert property (p_tx_cause) else $error("byte without take");
  a_tx_hold: assert property (p_tx_hold) else $error("byte changed idle");
endmodule
`default_nettype wire

// *** dv/uef_ctrl_model.sv ***
/*
 Endpoint controller model: pulses takes and stores, keeps the last endpoint 0
 byte taken and counts them. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_ctrl_model (
  // Clock
  input wire logic aclk,
  // Design side
  output logic [2:0] tx_take,
  input wire logic [2:0][7:0] tx_byte,
  input wire logic [2:0] tx_byte_valid,
  output logic [2:0] rx_store,
  output logic [2:0][7:0] rx_byte,
  // Collected bytes
  output logic [7:0] got_byte,
  output int got_cnt
);
  initial begin
    tx_take = 3'h0;
    rx_store = 3'h0;
    rx_byte = '0;
    got_byte = 8'h00;
    got_cnt = 0;
  end
  task automatic take(input int ep);
    @(posedge aclk) tx_take[ep] <= 1'b1;
    @(posedge aclk) tx_take[ep] <= 1'b0;
  endtask
  // Released data shows the inverse so a stale byte is never stored
  task automatic store(input int ep, input logic [7:0] d);
    @(posedge aclk);
    rx_store[ep] <= 1'b1;
    rx_byte[ep] <= d;
    @(posedge aclk);
    rx_store[ep] <= 1'b0;
    rx_byte[ep] <= ~d;
  endtask
  always @(posedge aclk) begin
    if (tx_byte_valid[0] === 1'b1) begin
      got_byte <= tx_byte[0];
      got_cnt <= got_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** dv/uef_tb.sv ***
/*
 Bench top: clock, reset, AXI4-Lite master, scenarios and verdict.
 Assumes the endpoint model and the bound checker beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module testbench;
  localparam logic [7:0] TXD = uef_pkg::TX_BASE + uef_pkg::DATA_OFS;
  localparam logic [7:0] TXS = uef_pkg::TX_BASE + uef_pkg::STAT_OFS;
  localparam logic [7:0] RXD = uef_pkg::RX_BASE + uef_pkg::DATA_OFS;
  localparam logic [7:0] RXS = uef_pkg::RX_BASE + uef_pkg::STAT_OFS;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, got_byte;
  logic [31:0] wdata = 32'h0, rd;
  logic [1:0] rsp;
  wire logic awready, wready, bvalid, arready, rvalid, usb_irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] tx_take, tx_byte_valid, rx_store;
  wire logic [2:0][7:0] tx_byte, rx_byte;
  int failures = 0, check_count = 0, cycles = 0, got_cnt;
  always #2 aclk = ~aclk;
  uef_top i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .tx_take, .tx_byte, .tx_byte_valid, .rx_store, .rx_byte, .usb_irq);
  uef_ctrl_model i_ctrl (.aclk, .tx_take, .tx_byte, .tx_byte_valid, .rx_store, .rx_byte,
    .got_byte, .got_cnt);
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard well above the roughly one thousand cycles the scenarios need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk) awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (wready !== 1'b1);
        @(posedge aclk) wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk) bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk) arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk) rready <= 1'b0;
  endtask
  task automatic take_one;
    i_ctrl.take(0);
    repeat (2) @(negedge aclk);
  endtask
  task automatic t_reset;
    axi_rd(TXS);
    `CHK(rd[6:0], uef_pkg::FIFO_SIZE);
    axi_rd(RXS);
    `CHK(rd, 32'h0);
    axi_rd(uef_pkg::FIFO_WARNING_ADDR);
    `CHK(rd[5:0], 6'h07);
    axi_rd(8'hFC);
    `CHK(rsp, uef_pkg::RESP_SLVERR);
    axi_wr(8'hFC, 32'h0);
    `CHK(rsp, uef_pkg::RESP_SLVERR);
    $display("t_reset done");
  endtask
  task automatic t_tx;
    int i;
    for (i = 0; i < uef_pkg::DEPTH; i++) axi_wr(TXD, {24'h0, 8'(i)});
    axi_wr(TXD, 32'hEE);
    `CHK(rsp, uef_pkg::RESP_OKAY);
    axi_rd(TXS);
    `CHK(rd[6:0], 7'h00);
    axi_rd(uef_pkg::FIFO_WARNING_ADDR);
    `CHK(rd[0], 1'b0);
    for (i = 0; i < uef_pkg::DEPTH; i++) begin
      take_one();
      `CHK(got_byte, 8'(i));
    end
    take_one();
    `CHK(got_cnt, 64);
    axi_rd(uef_pkg::MAIN_EVENT_ADDR);
    `CHK(rd[0], 1'b1);
    axi_wr(TXD, 32'h55);
    take_one();
    `CHK(got_byte, 8'h55);
    axi_wr(uef_pkg::MAIN_MASK_ADDR, 32'h01);
    @(negedge aclk);
    `CHK(usb_irq, 1'b0);
    axi_wr(uef_pkg::MAIN_MASK_ADDR, 32'h81);
    @(negedge aclk);
    `CHK(usb_irq, 1'b1);
    axi_wr(uef_pkg::MAIN_EVENT_ADDR, 32'h01);
    @(negedge aclk);
    `CHK(usb_irq, 1'b0);
    // Threshold 3: four bytes sit above it, one take brings the level onto it
    axi_wr(uef_pkg::TX_BASE + uef_pkg::CTRL_OFS, 32'h03);
    for (i = 0; i < 4; i++) axi_wr(TXD, 32'hA0);
    axi_rd(uef_pkg::FIFO_WARNING_ADDR);
    `CHK(rd[0], 1'b0);
    take_one();
    axi_rd(uef_pkg::FIFO_WARNING_ADDR);
    `CHK(rd[0], 1'b1);
    axi_wr(uef_pkg::FLUSH_ADDR, 32'h01);
    axi_rd(TXS);
    `CHK(rd[6:0], uef_pkg::FIFO_SIZE);
    // Final-chunk bit set: an empty take is no underrun
    axi_wr(uef_pkg::TX_BASE + uef_pkg::CMD_OFS, 32'h01);
    take_one();
    axi_rd(uef_pkg::MAIN_EVENT_ADDR);
    `CHK(rd[0], 1'b0);
    $display("t_tx done");
  endtask
  task automatic t_rx;
    int i;
    for (i = 0; i < uef_pkg::DEPTH + 1; i++) i_ctrl.store(0, 8'h80 + 8'(i));
    axi_rd(RXS);
    `CHK(rd[6:0], 7'h40);
    axi_rd(uef_pkg::MAIN_EVENT_ADDR);
    `CHK(rd[3], 1'b1);
    axi_rd(uef_pkg::FIFO_WARNING_ADDR);
    `CHK(rd[3], 1'b1);
    for (i = 0; i < uef_pkg::DEPTH; i++) begin
      axi_rd(RXD);
      `CHK(rd[7:0], 8'h80 + 8'(i));
    end
    axi_rd(RXD);
    `CHK(rd[7:0], 8'hBF);
    i_ctrl.store(0, 8'h12);
    axi_wr(uef_pkg::FLUSH_ADDR, 32'h08);
    axi_rd(RXS);
    `CHK(rd[6:0], 7'h00);
    $display("t_rx done");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    report_and_stop();
  end
endmodule
bind uef_top uef_props i_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .tx_take, .tx_byte, .tx_byte_valid);
`default_nettype wire
